// File: src/tct_cfg_if.sv
/*
 * Carrier between the register bank and its field decoder: raw words one way,
 * decoded settings the other.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface tct_cfg_if;
    logic [15:0] softmute_seek_word;
    logic [15:0] osc_test_word;
    logic powered_up;
    logic [3:0] volume_code;
    tct_pkg::tct_rate_e softmute_rate;
    logic [4:0] softmute_attenuation_db;
    logic [5:0] volume_attenuation_db;
    logic audio_mute;
    logic seek_snr_check_en;
    logic [3:0] seek_snr_threshold;
    logic seek_impulse_check_en;
    logic [3:0] seek_impulse_threshold;
    logic crystal_osc_enable;
    logic audio_hiz_active;

    modport bank (
        output softmute_seek_word, osc_test_word, powered_up, volume_code,
        input softmute_rate, softmute_attenuation_db, volume_attenuation_db, audio_mute,
        input seek_snr_check_en, seek_snr_threshold, seek_impulse_check_en, seek_impulse_threshold,
        input crystal_osc_enable, audio_hiz_active
    );
    modport dec (
        input softmute_seek_word, osc_test_word, powered_up, volume_code,
        output softmute_rate, softmute_attenuation_db, volume_attenuation_db, audio_mute,
        output seek_snr_check_en, seek_snr_threshold, seek_impulse_check_en, seek_impulse_threshold,
        output crystal_osc_enable, audio_hiz_active
    );
endinterface

`default_nettype wire

// File: src/tct_decode.sv
/*
 * Field decoder: turns the stored configuration words into the settings that
 * the audio and seek logic use, one clock after the word changes.
 * Assumes the bank drives the words from flip-flops on the same clock.
 */
`default_nettype none

module tct_decode (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Words in, settings out
    tct_cfg_if.dec cfg
);

    // ************************************************************
    // Field extraction
    // ************************************************************
    logic [1:0] rate_code;
    logic [1:0] atten_code;
    logic volume_extended;
    logic [3:0] snr_code;
    logic [3:0] impulse_code;
    logic [3:0] vol_steps;
    logic [5:0] next_volume_db;
    logic [4:0] next_atten_db;

    // Slices of the softmute and seek word
    assign rate_code = cfg.softmute_seek_word[tct_pkg::RATE_LSB +: 2];
    assign atten_code = cfg.softmute_seek_word[tct_pkg::ATTEN_LSB +: 2];
    assign volume_extended = cfg.softmute_seek_word[tct_pkg::EXTENDED_VOLUME_RANGE_BIT];
    assign snr_code = cfg.softmute_seek_word[tct_pkg::SNR_LSB +: 4];
    assign impulse_code = cfg.softmute_seek_word[tct_pkg::IMPULSE_LSB +: 4];

    // Depth falls 2 dB per code from 16 dB
    assign next_atten_db = tct_pkg::ATTEN_BASE_DB - 5'(tct_pkg::ATTEN_STEP_DB * 5'(atten_code));

    // Each step below full code adds 2 dB; extended range adds a fixed 30 dB
    assign vol_steps = tct_pkg::VOL_MAX_CODE - cfg.volume_code;
    assign next_volume_db = (cfg.volume_code == 4'h0) ? tct_pkg::MUTE_DB :
        6'((volume_extended ? tct_pkg::EXTENDED_VOLUME_RANGE_DB : 6'd0) + 6'(tct_pkg::VOL_STEP_DB * 6'(vol_steps)));

    // ************************************************************
    // Registered settings
    // ************************************************************
    // Code zero switches a seek check off rather than meaning a zero threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.softmute_rate <= tct_pkg::TCT_RATE_FASTEST;
            cfg.softmute_attenuation_db <= tct_pkg::ATTEN_BASE_DB;
            cfg.volume_attenuation_db <= tct_pkg::MUTE_DB;
            cfg.audio_mute <= 1'b1;
            cfg.seek_snr_check_en <= 1'b0;
            cfg.seek_snr_threshold <= 4'h0;
            cfg.seek_impulse_check_en <= 1'b0;
            cfg.seek_impulse_threshold <= 4'h0;
            cfg.crystal_osc_enable <= 1'b0;
            cfg.audio_hiz_active <= 1'b0;
        end else begin
            cfg.softmute_rate <= tct_pkg::tct_rate_e'(rate_code);
            cfg.softmute_attenuation_db <= next_atten_db;
            cfg.volume_attenuation_db <= next_volume_db;
            cfg.audio_mute <= (cfg.volume_code == 4'h0);
            cfg.seek_snr_check_en <= (snr_code != 4'h0);
            cfg.seek_snr_threshold <= snr_code;
            cfg.seek_impulse_check_en <= (impulse_code != 4'h0);
            cfg.seek_impulse_threshold <= impulse_code;
            cfg.crystal_osc_enable <= cfg.osc_test_word[tct_pkg::XOSC_BIT];
            // High-Z bias only while powered down
            cfg.audio_hiz_active <= cfg.osc_test_word[tct_pkg::AHIZ_BIT] & ~cfg.powered_up;
        end
    end

endmodule

`default_nettype wire

// File: src/tct_pkg.sv
/*
 * Constants for the tuner configuration and test register bank: register
 * indices, field positions, reset values and the figures used to decode fields.
 * Assumes nothing; it is compiled first.
 */
`default_nettype none

package tct_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned CFG_WORDS = 4;

    // ************************************************************
    // Register indices, byte address is four times the index
    // ************************************************************
    localparam logic [5:0] IDX_SOFTMUTE_SEEK = 6'h06;
    localparam logic [5:0] IDX_OSC_TEST = 6'h07;
    localparam logic [5:0] IDX_RESERVED_TEST = 6'h08;
    localparam logic [5:0] IDX_BOOT_CONFIG = 6'h09;
    localparam logic [5:0] IDX_POWER_CTRL = 6'h10;
    localparam logic [5:0] IDX_BANK_STATUS = 6'h11;

    // Slot codes returned by the address decoder
    localparam logic [2:0] SLOT_POWER = 3'h4;
    localparam logic [2:0] SLOT_STATUS = 3'h5;
    localparam logic [2:0] SLOT_NONE = 3'h7;

    // ************************************************************
    // Reset values, element 0 is the softmute and seek word
    // ************************************************************
    localparam logic [15:0] RST_SOFTMUTE_SEEK = 16'h0000;
    localparam logic [15:0] RST_OSC_TEST = 16'h0100;
    localparam logic [15:0] RST_RESERVED_TEST = 16'h0000;
    localparam logic [15:0] RST_BOOT_CONFIG = 16'h0000;
    localparam logic [3:0][15:0] CFG_RESET = {RST_BOOT_CONFIG, RST_RESERVED_TEST, RST_OSC_TEST, RST_SOFTMUTE_SEEK};
    localparam logic RST_POWERUP = 1'b0;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned RATE_LSB = 14;
    localparam int unsigned ATTEN_LSB = 12;
    localparam int unsigned EXTENDED_VOLUME_RANGE_BIT = 8;
    localparam int unsigned SNR_LSB = 4;
    localparam int unsigned IMPULSE_LSB = 0;
    localparam int unsigned XOSC_BIT = 15;
    localparam int unsigned AHIZ_BIT = 14;
    localparam int unsigned POWERUP_BIT = 0;
    localparam int unsigned STAT_POWERED_BIT = 0;
    localparam int unsigned STAT_OSC_BIT = 1;
    localparam int unsigned STAT_HIZ_BIT = 2;
    localparam int unsigned STAT_PATTERN_BIT = 3;

    // Required low bits of the oscillator test word per power state
    localparam logic [13:0] OSC_PATTERN_DOWN = 14'h0100;
    localparam logic [13:0] OSC_PATTERN_UP = 14'h3C04;

    // ************************************************************
    // Decoding figures in dB
    // ************************************************************
    localparam logic [4:0] ATTEN_BASE_DB = 5'd16;
    localparam logic [4:0] ATTEN_STEP_DB = 5'd2;
    localparam logic [5:0] EXTENDED_VOLUME_RANGE_DB = 6'd30;
    localparam logic [5:0] VOL_STEP_DB = 6'd2;
    localparam logic [3:0] VOL_MAX_CODE = 4'hF;
    localparam logic [5:0] MUTE_DB = 6'h3F;

    // Softmute attack and recovery speeds
    typedef enum logic [1:0] {
        TCT_RATE_FASTEST = 2'b00,
        TCT_RATE_FAST = 2'b01,
        TCT_RATE_SLOW = 2'b10,
        TCT_RATE_SLOWEST = 2'b11
    } tct_rate_e;

endpackage

`default_nettype wire

// File: src/tct_regs.sv
/*
 * Configuration and test register bank of an FM tuner, reached over APB.
 * Holds softmute, volume range and seek qualification settings, the crystal
 * oscillator and audio high-Z enables, and two reserved words.
 * Assumes an APB master on pclk and a volume code from the neighbouring bank.
 */
`default_nettype none

module tct_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Volume code from the neighbouring configuration word
    input wire logic [3:0] volume_code,
    // Audio settings
    output tct_pkg::tct_rate_e softmute_rate,
    output logic [4:0] softmute_attenuation_db,
    output logic [5:0] volume_attenuation_db,
    output logic audio_mute,
    // Seek qualification
    output logic seek_snr_check_en,
    output logic [3:0] seek_snr_threshold,
    output logic seek_impulse_check_en,
    output logic [3:0] seek_impulse_threshold,
    // Power and pins
    output logic crystal_osc_enable,
    output logic powerup_enable,
    output logic left_audio_out_hiz,
    output logic right_audio_out_hiz
);

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // Maps a byte address onto a slot; misaligned addresses map nowhere
    function automatic logic [2:0] slot_of(input logic [7:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        if (addr[1:0] != 2'b00) begin
            return tct_pkg::SLOT_NONE;
        end
        case (idx)
            tct_pkg::IDX_SOFTMUTE_SEEK: return 3'h0;
            tct_pkg::IDX_OSC_TEST: return 3'h1;
            tct_pkg::IDX_RESERVED_TEST: return 3'h2;
            tct_pkg::IDX_BOOT_CONFIG: return 3'h3;
            tct_pkg::IDX_POWER_CTRL: return tct_pkg::SLOT_POWER;
            tct_pkg::IDX_BANK_STATUS: return tct_pkg::SLOT_STATUS;
            default: return tct_pkg::SLOT_NONE;
        endcase
    endfunction

    // Byte lanes 0 and 1 carry the 16-bit word; upper lanes are ignored
    function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [31:0] wdata,
                                                input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic [15:0] cfg_word [tct_pkg::CFG_WORDS];
    logic powered_up;
    logic [2:0] bus_slot;
    logic bus_access;
    logic wr_en;
    logic rd_setup;
    logic [15:0] status_word;
    logic pattern_ok;
    logic [31:0] read_mux;

    // Zero wait states; the read word is caught in the setup cycle
    assign bus_slot = slot_of(paddr);
    assign bus_access = psel & penable;
    assign pready = 1'b1;
    assign pslverr = bus_access & (bus_slot == tct_pkg::SLOT_NONE);
    assign wr_en = bus_access & pwrite & pready & (bus_slot != tct_pkg::SLOT_NONE);
    assign rd_setup = psel & ~penable & ~pwrite;

    // Status shows the bank's own view of the power state
    assign pattern_ok = cfg_word[1][13:0] == (powered_up ? tct_pkg::OSC_PATTERN_UP : tct_pkg::OSC_PATTERN_DOWN);
    assign status_word = 16'({pattern_ok, left_audio_out_hiz, crystal_osc_enable, powered_up});

    // Read selection, unmapped and misaligned reads return zero
    always_comb begin
        read_mux = 32'h0000_0000;
        case (bus_slot)
            3'h0, 3'h1, 3'h2, 3'h3: read_mux = {16'h0000, cfg_word[bus_slot[1:0]]};
            tct_pkg::SLOT_POWER: read_mux = {31'h0000_0000, powered_up};
            tct_pkg::SLOT_STATUS: read_mux = {16'h0000, status_word};
            default: read_mux = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // Storage
    // ************************************************************
    // Every bit is stored as written, reserved ones included, so that a
    // read-modify-write of reserved bits returns exactly what was there
    for (genvar g = 0; g < tct_pkg::CFG_WORDS; g++) begin : g_word
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_word[g] <= tct_pkg::CFG_RESET[g];
            end else if (wr_en && bus_slot == 3'(g)) begin
                cfg_word[g] <= merge_lanes(cfg_word[g], pwdata, pstrb);
            end
        end
    end

    // Powerup enable; oscillator ordering is left to software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered_up <= tct_pkg::RST_POWERUP;
        end else if (wr_en && bus_slot == tct_pkg::SLOT_POWER && pstrb[0]) begin
            powered_up <= pwdata[tct_pkg::POWERUP_BIT];
        end
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= read_mux;
        end
    end

    // ************************************************************
    // Field decoder
    // ************************************************************
    tct_cfg_if cfg_bus ();

    assign cfg_bus.softmute_seek_word = cfg_word[0];
    assign cfg_bus.osc_test_word = cfg_word[1];
    assign cfg_bus.powered_up = powered_up;
    assign cfg_bus.volume_code = volume_code;

    tct_decode u_decode (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_bus.dec)
    );

    // Outputs come from the decoder's flip-flops, except powerup_enable, which is the bank's own powered_up flip-flop
    assign softmute_rate = cfg_bus.softmute_rate;
    assign softmute_attenuation_db = cfg_bus.softmute_attenuation_db;
    assign volume_attenuation_db = cfg_bus.volume_attenuation_db;
    assign audio_mute = cfg_bus.audio_mute;
    assign seek_snr_check_en = cfg_bus.seek_snr_check_en;
    assign seek_snr_threshold = cfg_bus.seek_snr_threshold;
    assign seek_impulse_check_en = cfg_bus.seek_impulse_check_en;
    assign seek_impulse_threshold = cfg_bus.seek_impulse_threshold;
    assign crystal_osc_enable = cfg_bus.crystal_osc_enable;
    assign powerup_enable = powered_up;
    assign left_audio_out_hiz = cfg_bus.audio_hiz_active;
    assign right_audio_out_hiz = cfg_bus.audio_hiz_active;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [1:0] wr_rate_field;
    logic [1:0] atten_field;
    logic [3:0] snr_field;
    logic [3:0] impulse_field;
    logic ext_field;
    logic hiz_field;

    assign wr_rate_field = pwdata[15:14];
    assign atten_field = cfg_word[0][13:12];
    assign snr_field = cfg_word[0][7:4];
    assign impulse_field = cfg_word[0][3:0];
    assign ext_field = cfg_word[0][8];
    assign hiz_field = cfg_word[1][14];

    // Full write of the upper byte of the softmute and seek word
    sequence s_wr_softmute;
        psel && penable && pwrite && pready && bus_slot == 3'h0 && pstrb[1];
    endsequence

    // Read of the oscillator word: setup then access
    sequence s_rd_osc;
        psel && !penable && !pwrite && bus_slot == 3'h1 ##1 psel && penable && pready;
    endsequence

    a_rate_write: assert property (s_wr_softmute |-> ##2 (softmute_rate == $past(wr_rate_field, 2)))
        else $error("softmute rate did not follow the written field");

    a_atten_depth: assert property ((atten_field == 2'b00 |=> softmute_attenuation_db == 5'd16) and
                                    (atten_field == 2'b11 |=> softmute_attenuation_db == 5'd10))
        else $error("softmute depth wrong for its code");

    a_extended_volume_range_span: assert property ((ext_field && volume_code == 4'h1) |=> volume_attenuation_db == 6'd58)
        else $error("extended volume range lowest step wrong");

    a_vol_mute_code: assert property ((volume_code == 4'h0) |=>
                                      (audio_mute && volume_attenuation_db == 6'h3F))
        else $error("volume code zero did not mute");

    a_vol_top_step: assert property ((ext_field && volume_code == 4'hF) |=>
                                     (!audio_mute && volume_attenuation_db == 6'd30))
        else $error("extended volume range top step wrong");

    a_snr_check: assert property ((snr_field == 4'h0 |=> !seek_snr_check_en) and
                                  (snr_field == 4'h7 |=> seek_snr_check_en && seek_snr_threshold == 4'h7))
        else $error("seek SNR threshold decode wrong");

    a_impulse_check: assert property ((impulse_field == 4'h0 |=> !seek_impulse_check_en) and
                                      (impulse_field == 4'hF |=>
                                       seek_impulse_check_en && seek_impulse_threshold == 4'hF))
        else $error("seek impulse threshold decode wrong");

    a_hiz_power: assert property ((powered_up |=> !left_audio_out_hiz && !right_audio_out_hiz) and
                                  (hiz_field && !powered_up |=> left_audio_out_hiz && right_audio_out_hiz))
        else $error("audio high-Z state wrong for power state");

    a_osc_read_back: assert property (s_rd_osc |-> prdata == {16'h0000, cfg_word[1]})
        else $error("oscillator word did not read back");

    a_reset_values: assert property ($rose(presetn) |-> cfg_word[1] == 16'h0100 && cfg_word[0] == 16'h0000)
        else $error("bank did not load its reset values");

    a_unmapped_error: assert property ((psel && penable && bus_slot == 3'h7) |-> pslverr && pready)
        else $error("unmapped access not answered with an error");

    // Refused writes must leave the softmute and seek word, the oscillator word and the power bit alone
    a_refused_write: assert property ((psel && penable && pwrite && bus_slot == tct_pkg::SLOT_NONE) |=>
                                      ($stable(cfg_word[0]) && $stable(cfg_word[1]) && $stable(powered_up)))
        else $error("refused write changed a stored word");

    // Power control follows lane 0 of the bus on the access edge
    sequence s_wr_power;
        psel && penable && pwrite && bus_slot == tct_pkg::SLOT_POWER && pstrb[0];
    endsequence

    a_power_write: assert property (s_wr_power |=> powerup_enable == $past(pwdata[tct_pkg::POWERUP_BIT]))
        else $error("powerup enable did not follow the write");

    // Audible steps sit 2 dB apart and a fixed 30 dB lower once the range is extended
    a_ext_shift: assert property ((ext_field && volume_code != 4'h0) |=>
                                  volume_attenuation_db == 6'(30 + 2 * (15 - $past(volume_code))))
        else $error("extended volume step off its scale");

    // Each stored word takes both lanes of a full write on the access edge
    for (genvar w = 0; w < tct_pkg::CFG_WORDS; w++) begin : g_chk_word
        a_word_store: assert property (@(posedge pclk) disable iff (!presetn)
            (psel && penable && pwrite && bus_slot == 3'(w) && pstrb[1:0] == 2'b11) |=>
            cfg_word[w] == $past(pwdata[15:0]))
            else $error("stored word differs from the data written");
    end

    // Status read tells software whether the oscillator word fits the power state
    sequence s_rd_status;
        psel && !penable && !pwrite && bus_slot == tct_pkg::SLOT_STATUS ##1 psel && penable;
    endsequence

    a_status_pattern: assert property (s_rd_status |->
                                       prdata[tct_pkg::STAT_PATTERN_BIT] ==
                                       $past(cfg_word[1][13:0] == (powered_up ? tct_pkg::OSC_PATTERN_UP :
                                                                   tct_pkg::OSC_PATTERN_DOWN)))
        else $error("status pattern bit wrong");

    // Refused reads return zero so stale data never leaks out
    sequence s_rd_refused;
        psel && !penable && !pwrite && bus_slot == tct_pkg::SLOT_NONE ##1 psel && penable;
    endsequence

    a_refused_read: assert property (s_rd_refused |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");

    // No error is raised outside an access phase
    a_error_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error raised outside an access phase");

endmodule

`default_nettype wire

// File: verification/tb.sv
/*
 * Self-checking bench for the tuner configuration and test register bank.
 * Assumes tct_pkg and tct_regs are compiled first and that pready may be waited on.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Signals, clock and the unit
    // ************************************************************
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0] pstrb = 4'h0, volume_code = 4'h0, snr_thr, imp_thr;
    logic pready, pslverr, mute, snr_en, imp_en, osc_en, pwr_en, hiz_l, hiz_r;
    tct_pkg::tct_rate_e rate;
    logic [4:0] sm_db;
    logic [5:0] vol_db;
    int err_count = 0, total_checks = 0;
    localparam logic [7:0] A_SMS = {tct_pkg::IDX_SOFTMUTE_SEEK, 2'b00}, A_OSC = {tct_pkg::IDX_OSC_TEST, 2'b00};
    localparam logic [7:0] A_PWR = {tct_pkg::IDX_POWER_CTRL, 2'b00};
    always #25 pclk = ~pclk; // 20 MHz
    tct_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .volume_code(volume_code), .softmute_rate(rate), .softmute_attenuation_db(sm_db),
        .volume_attenuation_db(vol_db), .audio_mute(mute), .seek_snr_check_en(snr_en),
        .seek_snr_threshold(snr_thr), .seek_impulse_check_en(imp_en), .seek_impulse_threshold(imp_thr),
        .crystal_osc_enable(osc_en), .powerup_enable(pwr_en), .left_audio_out_hiz(hiz_l),
        .right_audio_out_hiz(hiz_r));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Leading edge wait keeps release and next setup in different time steps
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n == 50) chk(1'b0, 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d}, 4'h3);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk(rd, exp);
    endtask
    // Decoded outputs lag the stored word by one clock
    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            rdc({tct_pkg::IDX_SOFTMUTE_SEEK + 6'(i), 2'b00}, {16'h0000, tct_pkg::CFG_RESET[i]});
        end
        chk({31'h0, osc_en}, 32'h0000_0000);
        chk({27'h0, sm_db}, 32'h0000_0010);
        chk({30'h0, rate}, 32'h0000_0000);
    endtask
    task automatic t_softmute;
        for (int i = 0; i < 4; i++) begin
            wr(A_SMS, 16'(i * 16'h5000));
            settle();
            chk({30'h0, rate}, i);
            chk({27'h0, sm_db}, 16 - 2 * i);
            rdc(A_SMS, i * 32'h5000);
        end
    endtask
    // Mute at code zero in both ranges, ends of the scale otherwise
    task automatic t_volume;
        logic [3:0] c;
        for (int x = 0; x < 2; x++) for (int k = 0; k < 4; k++) begin
            c = (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : (k == 2) ? 4'hE : 4'hF;
            @(posedge pclk);
            volume_code <= c;
            wr(A_SMS, 16'(x << 8));
            settle();
            chk({31'h0, mute}, c == 4'h0);
            chk({26'h0, vol_db}, (c == 4'h0) ? 63 : (15 - c) * 2 + 30 * x);
        end
    endtask
    task automatic t_seek;
        int v[4] = '{0, 1, 7, 15};
        foreach (v[i]) begin
            // SNR codes above 0111 are undefined, so the SNR field stops at 7
            wr(A_SMS, 16'(((v[i] & 7) << 4) | v[i]));
            settle();
            chk({31'h0, snr_en}, v[i] != 0);
            chk({28'h0, snr_thr}, v[i] & 7);
            chk({31'h0, imp_en}, v[i] != 0);
            chk({28'h0, imp_thr}, v[i]);
        end
    endtask
    // Oscillator up first, high-Z only while powered down
    task automatic t_power;
        wr(A_OSC, 16'hC100);
        settle();
        chk({30'h0, osc_en, hiz_l & hiz_r}, 32'h0000_0003);
        wr(A_PWR, 16'h0001);
        settle();
        chk({30'h0, pwr_en, hiz_l | hiz_r}, 32'h0000_0002);
        wr(A_OSC, 16'hFC04);
        settle();
        rdc(8'h44, 32'h0000_000B);
        wr(A_PWR, 16'h0000);
        settle();
        chk({31'h0, hiz_l & hiz_r}, 32'h0000_0001);
        wr(A_OSC, 16'hC100);
        rdc(8'h44, 32'h0000_000E);
        wr(A_OSC, 16'h0100);
        settle();
        chk({30'h0, osc_en, hiz_l | hiz_r}, 32'h0000_0000);
    endtask
    // Lane strobes, reserved words and refused addresses
    task automatic t_bus;
        rdc(8'h20, 32'h0000_0000);
        wr(8'h20, rd[15:0]);
        rdc(8'h20, 32'h0000_0000);
        apb(1'b1, A_SMS, 32'hFFFF_F1FF, 4'h2);
        rdc(A_SMS, 32'h0000_F17F);
        rdc(8'h30, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        apb(1'b1, 8'h19, 32'h0000_01FF, 4'h3);
        chk({31'h0, er}, 32'h0000_0001);
        rdc(A_SMS, 32'h0000_F17F);
    endtask
    // Reset in mid-run puts the softmute and seek word, the rate and the depth back to their reset values
    task automatic t_rereset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(A_SMS, 32'h0000_0000);
        chk({25'h0, rate, sm_db}, 32'h0000_0010);
    endtask
    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_softmute();
        t_volume();
        t_seek();
        t_power();
        t_bus();
        t_rereset();
        stop_test();
    end
    initial begin
        #(20000 * 50);
        err_count++;
        stop_test();
    end
endmodule

`default_nettype wire
